/* inc/adctrg_pkg.sv */
// Register map, field positions and reset values for the converter control block
package adctrg_pkg;
    localparam logic [7:0] OFF_PORT_A       = 8'h05;
    localparam logic [7:0] OFF_PORT_E       = 8'h09;
    localparam logic [7:0] OFF_INTCTL      = 8'h0B;
    localparam logic [7:0] OFF_FLAGS1       = 8'h0C;
    localparam logic [7:0] OFF_FLAGS2       = 8'h0D;
    localparam logic [7:0] OFF_RESULT       = 8'h1E;
    localparam logic [7:0] OFF_CTRL0        = 8'h1F;
    localparam logic [7:0] OFF_PORT_A_PINS_DIR    = 8'h85;
    localparam logic [7:0] OFF_PORT_E_PINS_DIR    = 8'h89;
    localparam logic [7:0] OFF_ENABLES1     = 8'h8C;
    localparam logic [7:0] OFF_ENABLES2     = 8'h8D;
    localparam logic [7:0] OFF_PIN_CFG      = 8'h9F;
    localparam logic [7:0] OFF_CMP2_CTRL    = 8'hA0;
    localparam logic [7:0] OFF_TIMER_LO     = 8'hA1;
    localparam logic [7:0] OFF_TIMER_HI     = 8'hA2;

    localparam int         BIT_GO           = 2;
    localparam int         BIT_ON           = 0;
    localparam int         BIT_DONE_FLAG    = 6;
    localparam int         BIT_GIE          = 7;
    localparam int         BIT_PERIPHERAL_IRQ_ENABLE         = 6;
    localparam logic [7:0] CTRL0_MASK       = 8'hFD;
    localparam logic [7:0] PIN_CFG_MASK     = 8'h07;
    localparam logic [7:0] PORT_A_PINS_DIR_MASK   = 8'h3F;
    localparam logic [7:0] PORT_E_PINS_DIR_MASK   = 8'hF7;
    localparam logic [7:0] FLAGS2_MASK      = 8'h01;
    localparam logic [7:0] RST_CTRL0        = 8'h00;
    localparam logic [7:0] RST_PORT_A_PINS_DIR    = 8'h3F;
    localparam logic [7:0] RST_PORT_E_PINS_DIR    = 8'h07;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [3:0] CMP2_SPECIAL     = 4'hB;
    localparam logic [7:0] CONV_CYCLES      = 8'h0A;

    typedef struct packed {
        logic       start;
        logic [7:0] data;
    } adctrg_sample_s;
endpackage

/* verif/adctrg_partner.sv */
// Compare unit special-event source and converter sample source
`timescale 1ns/1ns
module adctrg_partner
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    fire_i,
    input  wire logic [7:0]              value_i,
    output logic                         event_o,
    output adctrg_pkg::adctrg_sample_s   sample_o
);
    import adctrg_pkg::*;

    // Pulses on alternate cycles while the request is held
    always_ff @(posedge clk_i)
    begin
        event_o <= fire_i && !event_o && !rst_i;
    end

    // Sample follows the bench every cycle, no held copy
    always_ff @(posedge clk_i)
    begin
        sample_o <= '{start: fire_i, data: value_i};
    end
endmodule

/* verif/test_adc_trigger_and_register_control.sv */
// Self-checking bench for the converter trigger and register block
`timescale 1ns/1ns
module test_adc_trigger_and_register_control;
    import adctrg_pkg::*;
    logic           clk, rst, cyc, stb, we, fire, evt, ack, conv, irq;
    logic [7:0]     adr, val, q, r, a, v;
    logic [3:0]     sel;
    logic [31:0]    dat, rdat;
    logic [15:0]    tmr;
    logic [2:0]     chan;
    adctrg_sample_s smp;
    int             fails = 0;
    int             total_checks = 0;
    localparam logic [7:0] RA [8] = '{8'h1F, 8'h9F, 8'h85, 8'h89, 8'h0C, 8'h8C, 8'h0D, 8'h8D};
    localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h3F, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};

    adctrg_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .special_event_i(evt), .sample_i(smp), .timer_o(tmr), .channel_o(chan),
        .convert_o(conv), .irq_o(irq));
    adctrg_partner cmp_u (.clk_i(clk), .rst_i(rst), .fire_i(fire), .value_i(val),
        .event_o(evt), .sample_o(smp));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [7:0] wmask(input logic [7:0] x);
        case (x)
            8'h1F:   return 8'hFD;
            8'h9F:   return 8'h07;
            8'h85:   return 8'h3F;
            default: return 8'hF7;
        endcase
    endfunction

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic timeout_end;
        fails++;
        $display("Error %0t wait ran out", $time);
        complete_run();
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] x, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= x;
        sel <= s;
        dat <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        if (ack !== 1'b1)
            timeout_end();
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] x, input logic [7:0] d);
        wb(1'b1, x, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] x);
        wb(1'b0, x, 8'h00, 4'hF);
    endtask

    task automatic trig;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        while (conv !== 1'b0 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (conv !== 1'b0)
            timeout_end();
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        {rst, cyc, stb, we, fire, adr, sel, dat, val} = {1'b1, 56'h0};
        r = 8'($urandom(86155));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            rd(RA[i]);
            chk(q, RV[i]);
        end
        rd(OFF_INTCTL);
        chk(q & 8'hFE, 8'h00);
        rd(8'h40);
        chk(q, 8'h00);
        $display("Test reset values done");
        for (int i = 0; i < 16; i++)
        begin
            a = RA[i % 4];
            r = 8'($urandom()) & 8'hFA;
            wr(a, r);
            rd(a);
            chk(q, r & wmask(a));
        end
        v = q;
        wb(1'b1, 8'h89, ~v, 4'hE);
        rd(8'h89);
        chk(q, v);
        $display("Test register fields done");
        wr(OFF_CMP2_CTRL, 8'h0B);
        wr(OFF_FLAGS1, 8'h00);
        wr(OFF_INTCTL, 8'hC0);
        for (int k = 0; k < 2; k++)
        begin
            wr(OFF_ENABLES1, k ? 8'h00 : 8'h40);
            wr(OFF_TIMER_HI, 8'h80);
            wr(OFF_CTRL0, 8'h11);
            repeat (20) @(posedge clk);
            val <= 8'($urandom());
            trig();
            chk(tmr[15:8], 8'h00);
            chk({4'h0, tmr[7:4]}, 8'h00);
            chk({5'h00, chan}, 8'h02);
            rd(OFF_CTRL0);
            chk(q, 8'h15);
            wait_done();
            rd(OFF_CTRL0);
            chk(q, 8'h11);
            rd(OFF_RESULT);
            chk(q, val);
            chk({7'h00, irq}, k ? 8'h00 : 8'h01);
            rd(OFF_FLAGS1);
            chk(q, 8'h40);
            @(posedge clk);
            chk({7'h00, irq}, 8'h00);
        end
        $display("Test triggered conversion done");
        for (int k = 0; k < 2; k++)
        begin
            wr(OFF_CMP2_CTRL, k ? 8'h0B : 8'h0A);
            wr(OFF_CTRL0, k ? 8'h10 : 8'h11);
            wr(OFF_TIMER_HI, 8'h80);
            trig();
            chk(tmr[15:8], 8'h00);
            chk({7'h00, conv}, 8'h00);
            rd(OFF_CTRL0);
            chk(q, k ? 8'h10 : 8'h11);
        end
        $display("Test ignored trigger done");
        wr(OFF_CTRL0, 8'h11);
        wr(OFF_RESULT, 8'h5A);
        val <= ~val;
        trig();
        wr(OFF_CTRL0, 8'h11); // Clearing go mid-conversion
        repeat (15) @(posedge clk);
        chk({7'h00, conv}, 8'h00);
        rd(OFF_RESULT);
        chk(q, 8'h5A);
        wr(OFF_INTCTL, 8'hC1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFF_RESULT);
        chk(q, 8'h5A);
        rd(OFF_INTCTL);
        chk(q, 8'h01);
        rd(OFF_CTRL0);
        chk(q, 8'h00);
        $display("Test abort and reset done");
        complete_run();
    end
endmodule

/* verilog/adctrg_top.sv */
// Converter control: Wishbone registers, trigger, timer clear and conversion sequencer
`timescale 1ns/1ns
module adctrg_top
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  special_event_i,
    input  wire adctrg_pkg::adctrg_sample_s sample_i,
    output logic      [15:0]           timer_o,
    output logic      [2:0]            channel_o,
    output logic                       convert_o,
    output logic                       irq_o
);
    import adctrg_pkg::*;

    logic [7:0]  ctrl0;
    logic [7:0]  result;
    logic [7:0]  pin_cfg;
    logic [7:1]  intctl_hi;
    logic        intctl_lo;
    logic [7:0]  flags1;
    logic [7:0]  flags2;
    logic [7:0]  enables1;
    logic [7:0]  enables2;
    logic [7:0]  port_a_pins;
    logic [7:0]  port_e_pins;
    logic [7:0]  port_a_pins_dir;
    logic [7:0]  port_e_pins_dir;
    logic [3:0]  cmp2_mode;
    logic [15:0] timer;
    logic [7:0]  conv_cnt;
    logic        busy;
    logic        evt_q;
    logic [7:0]  next_rdata;

    logic        wr;
    logic        rd;
    logic        wr0;
    logic        trig;
    logic        fire;
    logic        done;

    assign wr   = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    assign wr0  = wr;
    // Edge detect so a held trigger starts only one conversion
    assign trig = special_event_i && !evt_q;
    assign fire = trig && (cmp2_mode == CMP2_SPECIAL) && ctrl0[BIT_ON];
    assign done = busy && (conv_cnt == CONV_CYCLES) && ctrl0[BIT_GO];

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            evt_q <= 1'b0;
        else
            evt_q <= special_event_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl0 <= RST_CTRL0;
        else
        begin
            if (wr0 && hit(wb_adr_i, OFF_CTRL0))
                ctrl0 <= wb_dat_i[7:0] & CTRL0_MASK;
            if (fire)
                ctrl0[BIT_GO] <= 1'b1;
            else if (done)
                ctrl0[BIT_GO] <= 1'b0;
        end
    end

    // Sequencer: fixed length conversion, abort when go drops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy     <= 1'b0;
            conv_cnt <= RST_ZERO;
        end
        else if (!ctrl0[BIT_GO] || !ctrl0[BIT_ON] || done)
        begin
            busy     <= 1'b0;
            conv_cnt <= RST_ZERO;
        end
        else
        begin
            busy     <= 1'b1;
            conv_cnt <= conv_cnt + 8'h01;
        end
    end

    // No reset: contents survive all resets
    always_ff @(posedge clk_i)
    begin
        if (done)
            result <= sample_i.data;
        else if (wr0 && hit(wb_adr_i, OFF_RESULT))
            result <= wb_dat_i[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            timer <= 16'h0000;
        else if (trig)
            timer <= 16'h0000;
        else if (wr0 && hit(wb_adr_i, OFF_TIMER_LO))
            timer[7:0] <= wb_dat_i[7:0];
        else if (wr0 && hit(wb_adr_i, OFF_TIMER_HI))
            timer[15:8] <= wb_dat_i[7:0];
        else
            timer <= timer + 16'h0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_cfg   <= RST_ZERO;
            enables1  <= RST_ZERO;
            enables2  <= RST_ZERO;
            flags2    <= RST_ZERO;
            port_a_pins_dir <= RST_PORT_A_PINS_DIR;
            port_e_pins_dir <= RST_PORT_E_PINS_DIR;
            cmp2_mode <= 4'h0;
            intctl_hi <= 7'h00;
        end
        else if (wr0)
        begin
            if (hit(wb_adr_i, OFF_PIN_CFG))
                pin_cfg <= wb_dat_i[7:0] & PIN_CFG_MASK;
            if (hit(wb_adr_i, OFF_ENABLES1))
                enables1 <= wb_dat_i[7:0];
            if (hit(wb_adr_i, OFF_ENABLES2))
                enables2 <= wb_dat_i[7:0] & FLAGS2_MASK;
            if (hit(wb_adr_i, OFF_FLAGS2))
                flags2 <= wb_dat_i[7:0] & FLAGS2_MASK;
            if (hit(wb_adr_i, OFF_PORT_A_PINS_DIR))
                port_a_pins_dir <= wb_dat_i[7:0] & PORT_A_PINS_DIR_MASK;
            if (hit(wb_adr_i, OFF_PORT_E_PINS_DIR))
                port_e_pins_dir <= wb_dat_i[7:0] & PORT_E_PINS_DIR_MASK;
            if (hit(wb_adr_i, OFF_CMP2_CTRL))
                cmp2_mode <= wb_dat_i[3:0];
            if (hit(wb_adr_i, OFF_INTCTL))
                intctl_hi <= wb_dat_i[7:1];
        end
    end

    // Bit 0 holds across reset, only a write changes it
    always_ff @(posedge clk_i)
    begin
        if (wr0 && hit(wb_adr_i, OFF_INTCTL))
            intctl_lo <= wb_dat_i[0];
    end

    // Port data latches hold across reset
    always_ff @(posedge clk_i)
    begin
        if (wr0 && hit(wb_adr_i, OFF_PORT_A))
            port_a_pins <= wb_dat_i[7:0] & PORT_A_PINS_DIR_MASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (wr0 && hit(wb_adr_i, OFF_PORT_E))
            port_e_pins <= wb_dat_i[7:0] & PIN_CFG_MASK;
    end

    // Flags: a completion beats a clear in the same cycle, also a read clears
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags1 <= RST_ZERO;
        else
        begin
            if (rd && hit(wb_adr_i, OFF_FLAGS1))
                flags1 <= RST_ZERO;
            else if (wr0 && hit(wb_adr_i, OFF_FLAGS1))
                flags1 <= wb_dat_i[7:0];
            if (done)
                flags1[BIT_DONE_FLAG] <= 1'b1;
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        case (wb_adr_i)
            OFF_PORT_A:    next_rdata = port_a_pins;
            OFF_PORT_E:    next_rdata = port_e_pins;
            OFF_INTCTL:    next_rdata = {intctl_hi, intctl_lo};
            OFF_FLAGS1:    next_rdata = flags1;
            OFF_FLAGS2:    next_rdata = flags2;
            OFF_RESULT:    next_rdata = result;
            OFF_CTRL0:     next_rdata = ctrl0 & CTRL0_MASK;
            OFF_PORT_A_PINS_DIR: next_rdata = port_a_pins_dir;
            OFF_PORT_E_PINS_DIR: next_rdata = port_e_pins_dir;
            OFF_ENABLES1:  next_rdata = enables1;
            OFF_ENABLES2:  next_rdata = enables2;
            OFF_PIN_CFG:   next_rdata = pin_cfg;
            OFF_CMP2_CTRL: next_rdata = {4'h0, cmp2_mode};
            OFF_TIMER_LO:  next_rdata = timer[7:0];
            OFF_TIMER_HI:  next_rdata = timer[15:8];
            default:       next_rdata = 8'h00;
        endcase
    end

    // Single-cycle ack; unmapped reads return zero, writes are dropped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= {24'h000000, next_rdata};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o     <= 1'b0;
            timer_o   <= 16'h0000;
            channel_o <= 3'h0;
            convert_o <= 1'b0;
        end
        else
        begin
            irq_o     <= intctl_hi[BIT_GIE] && intctl_hi[BIT_PERIPHERAL_IRQ_ENABLE] && |(flags1 & enables1);
            timer_o   <= timer;
            channel_o <= ctrl0[5:3];
            convert_o <= busy;
        end
    end

    // Reset checks carry no disable so that they can watch the reset itself
    go_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fire |=> ctrl0[BIT_GO])
        else $error("go not set by event");

    mode_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig && cmp2_mode != CMP2_SPECIAL && !ctrl0[BIT_GO] && !wr0) |=> !ctrl0[BIT_GO])
        else $error("event taken in wrong mode");

    busy_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        busy |=> convert_o)
        else $error("convert output not following busy");

    tmr_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        trig |=> timer == 16'h0000)
        else $error("timer not cleared");

    tmr_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!trig && !(wr0 && (hit(wb_adr_i, OFF_TIMER_LO) || hit(wb_adr_i, OFF_TIMER_HI))))
            |=> timer == $past(timer) + 16'h0001) else $error("timer not counting");

    off_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig && !ctrl0[BIT_ON] && !ctrl0[BIT_GO] && !wr0) |=> !ctrl0[BIT_GO])
        else $error("event not ignored");

    off_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (trig && !ctrl0[BIT_ON]) |=> timer == 16'h0000)
        else $error("timer kept with converter off");

    ctrl_bit1_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl0[1])
        else $error("control bit1 set");

    ctrl_reset_a: assert property (@(posedge clk_i)
        rst_i |=> ctrl0 == RST_CTRL0)
        else $error("control reset value");

    pincfg_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pin_cfg[7:3] == 5'h00)
        else $error("pin config upper bits");

    pincfg_reset_a: assert property (@(posedge clk_i)
        rst_i |=> pin_cfg == RST_ZERO)
        else $error("pin config reset value");

    done_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (done && !fire) |=> flags1[BIT_DONE_FLAG] && !ctrl0[BIT_GO])
        else $error("done flag");

    flags_reset_a: assert property (@(posedge clk_i)
        rst_i |=> flags1 == RST_ZERO && enables1 == RST_ZERO)
        else $error("flag or enable reset value");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && hit(wb_adr_i, OFF_FLAGS1) && !done) |=> flags1 == RST_ZERO)
        else $error("flags not cleared by read");

    irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ((flags1 & enables1) == RST_ZERO) |=> !irq_o)
        else $error("interrupt without enabled flag");

    irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (intctl_hi[BIT_GIE] && intctl_hi[BIT_PERIPHERAL_IRQ_ENABLE] && flags1[6] && enables1[6]) |=> irq_o)
        else $error("interrupt missing");

    intctl_reset_a: assert property (@(posedge clk_i)
        rst_i |=> intctl_hi == 7'h00)
        else $error("interrupt control reset value");

    intctl_kept_a: assert property (@(posedge clk_i)
        (rst_i && intctl_lo && !(wr0 && hit(wb_adr_i, OFF_INTCTL))) |=> intctl_lo)
        else $error("interrupt control bit0 lost");

    dir_reset_a: assert property (@(posedge clk_i)
        rst_i |=> port_a_pins_dir == RST_PORT_A_PINS_DIR && port_e_pins_dir == RST_PORT_E_PINS_DIR)
        else $error("direction reset value");

    port_e_pins_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !port_e_pins_dir[3] && port_a_pins_dir[7:6] == 2'h0)
        else $error("direction bits");

    abort_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl0[BIT_GO] && !(wr0 && hit(wb_adr_i, OFF_RESULT))) |=> $stable(result))
        else $error("result changed without completion");

    abort_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy && !ctrl0[BIT_GO]) |=> !busy)
        else $error("conversion not aborted");

    result_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done |=> result == $past(sample_i.data))
        else $error("result not loaded");

    go_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy && ctrl0[BIT_GO] && !done && !(wr0 && hit(wb_adr_i, OFF_CTRL0))) |=> ctrl0[2])
        else $error("go dropped before completion");

    done_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (done && !fire) |=> !done)
        else $error("completion repeated");

    once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        trig |=> !trig)
        else $error("double trigger");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");
endmodule
